// >>> testbench/tb_tdc_cmd_decode.sv
/*
  Self-checking bench of the command decoder: a cycle model of the
  descriptor stream plus register and interrupt scenarios.
  Assumes the host model feeds descriptors and the bench drives the rest.
*/
`timescale 1ns/1ps
`include "tdc_params.svh"

module tb_tdc_cmd_decode;
  import tdc_pkg::*;
  logic sys_clk_i, rst_i, reg_we_i, reg_re_i, desc_valid_i, desc_ready_o;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  tdc_cmd_t command_byte_i;
  logic [3:0] descriptor_type_field_i;
  tdc_len_t buffer_byte_length_i, payload_total_length_i;
  logic [15:0] desc_special_i, vlan_tag_o, ethertype_o, tag_type, e_vtag, l_s;
  logic tx_done_i, tx_error_i, tx_final_i, frame_valid_o, tag_insert_o, fcs_insert_o;
  logic seg_ctx_o, seg_abort_o, descriptor_done_flag_o, head_advance_o, irq_o;
  logic e_fv, e_done, e_head, e_ab, e_rdy, e_tins, e_fins, e_sctx, tag_en, l_t, l_f;
  int err_total, cmp_count, cyc, m_wait, m_open, m_rem, m_abort, seed;

  tdc_cmd_decode dut (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
    .reg_rdata_o, .desc_valid_i, .desc_ready_o, .command_byte_i, .descriptor_type_field_i,
    .buffer_byte_length_i, .desc_special_i, .payload_total_length_i, .tx_done_i,
    .tx_error_i, .tx_final_i, .frame_valid_o, .tag_insert_o, .fcs_insert_o, .vlan_tag_o,
    .ethertype_o, .seg_ctx_o, .seg_abort_o, .descriptor_done_flag_o, .head_advance_o,
    .irq_o);
  tdc_host_model host (.sys_clk_i, .desc_ready_i(desc_ready_o), .desc_valid_o(desc_valid_i),
    .cmd_o(command_byte_i), .type_o(descriptor_type_field_i), .len_o(buffer_byte_length_i),
    .spec_o(desc_special_i), .pay_o(payload_total_length_i));

  // 200 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------------------------------
  // Cycle model: predicts the pulses that follow each edge
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i or posedge rst_i) begin
    logic t, f;
    logic [15:0] s;
    {e_fv, e_done, e_head, e_ab} = '0;
    if (rst_i) begin
      m_wait = 0;
      m_open = 0;
    end else if (m_wait != 0) begin
      if ((tx_done_i | tx_error_i) & tx_final_i) begin
        e_done = 1'b1;
        e_head = 1'b1;
        m_wait = 0;
      end
    end else if (desc_valid_i) begin
      t = command_byte_i[6];
      f = command_byte_i[1];
      s = desc_special_i;
      if (!command_byte_i[5] || descriptor_type_field_i !== 4'h1) begin
        e_head = 1'b1;
      end else begin
        if (command_byte_i[2]) begin
          if (m_open == 0) begin
            m_open = 1;
            m_rem = payload_total_length_i;
            {l_t, l_f, l_s} = {t, f, s};
          end
          {t, f, s} = {l_t, l_f, l_s};
          if (command_byte_i[0]) begin
            if (buffer_byte_length_i != 16'(m_rem)) begin
              e_ab = 1'b1;
              m_abort++;
            end
            m_open = 0;
          end else m_rem -= buffer_byte_length_i;
        end
        if (command_byte_i[0]) begin
          e_fv = 1'b1;
          e_tins = t & tag_en;
          e_fins = e_tins | f;
          e_vtag = s;
          e_sctx = command_byte_i[2];
        end
        if (command_byte_i[3] & command_byte_i[4]) m_wait = 1;
        else begin
          e_done = command_byte_i[3];
          e_head = 1'b1;
        end
      end
    end
    e_rdy = (m_wait == 0);
  end

  // Compare every cycle where outputs have settled
  always @(negedge sys_clk_i) begin
    if (!rst_i) begin
      check("ready", desc_ready_o, e_rdy);
      check("head", head_advance_o, e_head);
      check("done", descriptor_done_flag_o, e_done);
      check("frame", frame_valid_o, e_fv);
      check("abort", seg_abort_o, e_ab);
      if (e_fv) begin
        check("tag_ins", tag_insert_o, e_tins);
        check("fcs_ins", fcs_insert_o, e_fins);
        check("seg_ctx", seg_ctx_o, e_sctx);
        if (e_tins) check("vlan", vlan_tag_o, e_vtag);
        if (e_tins) check("etype", ethertype_o, tag_type);
      end
    end
  end

  // Hang guard, far above the planned run
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Tasks: entered just after a rising edge, leave after one
  // ----------------------------------------------------------------
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_we_i <= 1'b0;
    if (a == `TDC_OFS_CTRL) tag_en <= d[0];
    if (a == `TDC_OFS_TAG_TYPE) tag_type <= d[15:0];
    @(posedge sys_clk_i);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input bit chk);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_re_i <= 1'b0;
    #1;
    if (chk) check("rdata", reg_rdata_o, e);
    @(posedge sys_clk_i);
  endtask

  task automatic tx(input logic err, input logic fin);
    tx_done_i <= !err;
    tx_error_i <= err;
    tx_final_i <= fin;
    @(posedge sys_clk_i);
    {tx_done_i, tx_error_i, tx_final_i} <= 3'b000;
    repeat (2) @(posedge sys_clk_i);
  endtask

  task automatic irq_is(input logic e);
    @(negedge sys_clk_i);
    check("irq", irq_o, e);
    @(posedge sys_clk_i);
  endtask

  task automatic one(input logic [7:0] c, input int gap);
    host.send(c, 1'b0, 16'd64, 16'h0, 16'd64);
    host.idle();
    repeat (gap) @(posedge sys_clk_i);
  endtask

  task automatic final_report();
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = $urandom(32'h5325e129);
    {rst_i, reg_we_i, reg_re_i, tx_done_i, tx_error_i, tx_final_i} = 6'b100000;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    {tag_en, tag_type, err_total, cmp_count, cyc, m_abort} = {1'b0, 16'h8100, 128'h0};
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    // Reset values, then an unmapped offset
    for (int i = 0; i < 8; i++) rd(8'(i * 4), (i == 2) ? 32'h8100 : 32'h0, 1'b1);
    wr(`TDC_OFS_DELAY, 32'hffff_0014);
    rd(`TDC_OFS_DELAY, 32'h14, 1'b1);
    wr(`TDC_OFS_SEG_ABORT, 32'h5);
    rd(`TDC_OFS_SEG_ABORT, 32'h0, 1'b1);
    wr(`TDC_OFS_TAG_TYPE, {16'h0, 16'($urandom)});
    // Plain descriptors, random flags, tag enable toggled, some back to back
    // report-on-wire bit kept clear here
    for (int i = 0; i < 40; i++) begin
      if (i % 10 == 0) wr(`TDC_OFS_CTRL, 32'((i / 10) % 2));
      host.send(8'($urandom) & 8'h4b, 1'b0, 16'($urandom), 16'($urandom), 16'h0);
      if ($urandom_range(0, 2) == 0) host.idle();
    end
    host.idle();
    host.send(8'h29, 1'b1, 16'd8, 16'h0, 16'h0);
    host.send(8'h09, 1'b1, 16'd8, 16'h0, 16'h0);
    host.idle();
    rd(`TDC_OFS_IRQ_STAT, 32'h0, 1'b0);
    // Segmentation: matched context, then a short one that aborts
    wr(`TDC_OFS_IRQ_MASK, 32'h2);
    host.send(8'h46, 1'b0, 16'd100, 16'h1234, 16'd300);
    host.send(8'h04, 1'b0, 16'd100, 16'h0bad, 16'd0);
    host.send(8'h05, 1'b0, 16'd100, 16'h0bad, 16'd0);
    host.send(8'h04, 1'b0, 16'd50, 16'h0777, 16'd200);
    host.send(8'h05, 1'b0, 16'd100, 16'h0bad, 16'd0);
    host.idle();
    repeat (3) @(posedge sys_clk_i);
    irq_is(1'b1);
    rd(`TDC_OFS_SEG_ABORT, 32'(m_abort), 1'b1);
    rd(`TDC_OFS_IRQ_STAT, 32'h2, 1'b1);
    // Report on wire: later descriptor stalls until final packet
    fork
      begin
        one(8'h19, 0);
        one(8'h09, 0);
      end
      begin
        repeat (4) @(posedge sys_clk_i);
        rd(`TDC_OFS_ENGINE, 32'h1, 1'b1);
        tx(1'b0, 1'b0);
        tx(1'b1, 1'b1);
      end
    join
    fork
      one(8'h9d, 0);
      begin
        repeat (3) @(posedge sys_clk_i);
        tx(1'b0, 1'b0);
        tx(1'b0, 1'b0);
        tx(1'b0, 1'b1);
      end
    join
    // Delayed interrupt: load, expiry, reload, immediate clear
    wr(`TDC_OFS_DELAY, 32'd20);
    wr(`TDC_OFS_IRQ_MASK, 32'h1);
    rd(`TDC_OFS_IRQ_STAT, 32'h0, 1'b0);
    one(8'ha9, 5);
    rd(`TDC_OFS_IRQ_STAT, 32'h0, 1'b1);
    repeat (20) @(posedge sys_clk_i);
    irq_is(1'b1);
    rd(`TDC_OFS_IRQ_STAT, 32'h1, 1'b1);
    irq_is(1'b0);
    one(8'ha9, 12);
    one(8'ha9, 12);
    rd(`TDC_OFS_IRQ_STAT, 32'h0, 1'b1);
    repeat (14) @(posedge sys_clk_i);
    rd(`TDC_OFS_IRQ_STAT, 32'h1, 1'b1);
    one(8'ha9, 5);
    one(8'h29, 1);
    rd(`TDC_OFS_IRQ_STAT, 32'h1, 1'b1);
    repeat (30) @(posedge sys_clk_i);
    rd(`TDC_OFS_IRQ_STAT, 32'h0, 1'b1);
    // Masked source stays quiet though status is set
    wr(`TDC_OFS_IRQ_MASK, 32'h0);
    one(8'h29, 3);
    irq_is(1'b0);
    rd(`TDC_OFS_IRQ_STAT, 32'h1, 1'b1);
    final_report();
  end
endmodule

// >>> testbench/tdc_host_model.sv
/*
  Host-side descriptor source: presents already fetched descriptors on
  the valid/ready stream of the command decoder.
  Assumes its tasks are entered just after a rising clock edge.
*/
`timescale 1ns/1ps

module tdc_host_model (
  // Clock and handshake
  input wire logic sys_clk_i,
  input wire logic desc_ready_i,
  // Descriptor toward the decoder
  output logic desc_valid_o,
  output logic [7:0] cmd_o,
  output logic [3:0] type_o,
  output logic [15:0] len_o,
  output logic [15:0] spec_o,
  output logic [15:0] pay_o
);
  // Quiet stream at time zero
  initial begin
    desc_valid_o = 1'b0;
    {cmd_o, type_o, len_o, spec_o, pay_o} = '0;
  end

  // Offer one descriptor and hold it until the decoder takes it
  task automatic send(input logic [7:0] c, input logic raw, input logic [15:0] l,
                      input logic [15:0] s, input logic [15:0] p);
    desc_valid_o <= 1'b1;
    cmd_o <= raw ? c : (c | 8'h20);
    type_o <= (raw && c[5]) ? 4'h2 : 4'h1;
    len_o <= l;
    spec_o <= s;
    pay_o <= p;
    // A stuck engine is left to the bench's hang guard
    do begin
      @(posedge sys_clk_i);
    end while (!desc_ready_i);
  endtask

  // Released command, length and special fields flip so stale values never look valid
  task automatic idle();
    desc_valid_o <= 1'b0;
    cmd_o <= ~cmd_o;
    len_o <= ~len_o;
    spec_o <= ~spec_o;
    @(posedge sys_clk_i);
  endtask
endmodule

// >>> verilog/tdc_cmd_decode.sv
/*
  Command byte decoder of the transmit data descriptor engine: frame
  controls, segmentation context, status write-back and delayed interrupt.
  Assumes descriptors arrive already fetched and buffered, one per
  accepted cycle, and that the transmitter reports packet completion.
*/
`timescale 1ns/1ps
`include "tdc_params.svh"

module tdc_cmd_decode #(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [`TDC_ADDR_W-1:0] reg_addr_i,
  input wire logic [`TDC_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [`TDC_DATA_W-1:0] reg_rdata_o,
  // Descriptor stream
  input wire logic desc_valid_i,
  output logic desc_ready_o,
  input wire tdc_pkg::tdc_cmd_t command_byte_i,
  input wire logic [3:0] descriptor_type_field_i,
  input wire tdc_pkg::tdc_len_t buffer_byte_length_i,
  input wire logic [15:0] desc_special_i,
  input wire tdc_pkg::tdc_len_t payload_total_length_i,
  // Transmit completion
  input wire logic tx_done_i,
  input wire logic tx_error_i,
  input wire logic tx_final_i,
  // Frame controls
  output logic frame_valid_o,
  output logic tag_insert_o,
  output logic fcs_insert_o,
  output logic [15:0] vlan_tag_o,
  output logic [15:0] ethertype_o,
  output logic seg_ctx_o,
  output logic seg_abort_o,
  // Write-back, ring and interrupt
  output logic descriptor_done_flag_o,
  output logic head_advance_o,
  output logic irq_o
);
  import tdc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    tdc_fsm_t fsm;
    logic global_tag_enable;
    logic [15:0] delay_value_field;
    logic [15:0] tag_type;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [`TDC_DATA_W-1:0] rdata;
    logic in_ctx;
    tdc_len_t remaining;
    logic smp_tag;
    logic smp_fcs;
    logic [15:0] smp_special;
    logic pend_ide;
    logic frame_valid;
    logic tag_insert;
    logic fcs_insert;
    logic [15:0] vlan_tag;
    logic [15:0] ethertype;
    logic seg_ctx;
    logic seg_abort;
    logic wb_valid;
    logic head_adv;
    logic irq;
  } tdc_st_t;

  tdc_st_t q, d;
  tdc_timer_if tif();
  logic [CNT_W-1:0] abort_count;
  logic abort_inc;
  logic accept;
  logic fmt_ok;
  logic resolve;
  logic wb;
  logic ide_wb;
  logic tload;
  logic tclr;
  logic tag_v;
  logic fcs_v;
  logic [15:0] spec_v;
  tdc_len_t rem_cur;
  logic ctx_first;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  tdc_delay_timer #(
    .DLY_W(16)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .tmr(tif.tmr)
  );

  tdc_stat_counter #(
    .W(CNT_W)
  ) u_seg_abort_counter (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .inc_i(abort_inc),
    .count_o(abort_count)
  );

  assign tif.load = tload;
  assign tif.clear = tclr;
  assign tif.value = q.delay_value_field;

  // Stalling the stream while a wire report is pending keeps order simple
  assign accept = desc_valid_i && (q.fsm == TDC_IDLE);
  assign fmt_ok = command_byte_i[`TDC_CMD_EXT_FMT] &&
                  (descriptor_type_field_i == `TDC_DTYPE_DATA);
  assign resolve = (q.fsm == TDC_WAIT) && (tx_done_i || tx_error_i) && tx_final_i;
  assign ctx_first = command_byte_i[`TDC_CMD_SEG_OFF] && !q.in_ctx;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.rdata = '0;
    d.frame_valid = 1'b0;
    d.seg_abort = 1'b0;
    d.wb_valid = 1'b0;
    d.head_adv = 1'b0;
    abort_inc = 1'b0;
    wb = 1'b0;
    ide_wb = 1'b0;
    tload = 1'b0;
    tclr = 1'b0;
    rem_cur = q.remaining;
    // first of context or this one
    tag_v = command_byte_i[`TDC_CMD_TAG_INS];
    fcs_v = command_byte_i[`TDC_CMD_FCS_INS];
    spec_v = desc_special_i;
    if (command_byte_i[`TDC_CMD_SEG_OFF] && q.in_ctx) begin
      tag_v = q.smp_tag;
      fcs_v = q.smp_fcs;
      spec_v = q.smp_special;
    end

    // Register reads; a status read clears it, later sets still win
    if (reg_re_i) begin
      case (reg_addr_i)
        `TDC_OFS_CTRL: d.rdata[`TDC_CTRL_TAG_EN] = q.global_tag_enable;
        `TDC_OFS_DELAY: d.rdata[15:0] = q.delay_value_field;
        `TDC_OFS_TAG_TYPE: d.rdata[15:0] = q.tag_type;
        `TDC_OFS_IRQ_STAT: begin
          d.rdata[1:0] = q.irq_stat;
          d.irq_stat = '0;
        end
        `TDC_OFS_IRQ_MASK: d.rdata[1:0] = q.irq_mask;
        `TDC_OFS_SEG_ABORT: d.rdata[CNT_W-1:0] = abort_count;
        `TDC_OFS_ENGINE: begin
          d.rdata[`TDC_ENG_WAIT] = (q.fsm == TDC_WAIT);
          d.rdata[`TDC_ENG_IN_CTX] = q.in_ctx;
        end
        default: d.rdata = '0;
      endcase
    end

    // Register writes
    if (reg_we_i) begin
      case (reg_addr_i)
        `TDC_OFS_CTRL: d.global_tag_enable = reg_wdata_i[`TDC_CTRL_TAG_EN];
        `TDC_OFS_DELAY: d.delay_value_field = reg_wdata_i[15:0];
        `TDC_OFS_TAG_TYPE: d.tag_type = reg_wdata_i[15:0];
        `TDC_OFS_IRQ_MASK: d.irq_mask = reg_wdata_i[1:0];
        default: d.rdata = d.rdata;
      endcase
    end

    if (accept && fmt_ok) begin
      if (command_byte_i[`TDC_CMD_SEG_OFF]) begin
        if (!q.in_ctx) begin
          rem_cur = payload_total_length_i;
          d.smp_tag = command_byte_i[`TDC_CMD_TAG_INS];
          d.smp_fcs = command_byte_i[`TDC_CMD_FCS_INS];
          d.smp_special = desc_special_i;
        end
        d.in_ctx = !command_byte_i[`TDC_CMD_LAST_BUF];
        d.remaining = rem_cur - buffer_byte_length_i;
        if (command_byte_i[`TDC_CMD_LAST_BUF] && (buffer_byte_length_i != rem_cur)) begin
          d.seg_abort = 1'b1;
          abort_inc = 1'b1;
          d.irq_stat[`TDC_IRQ_ABORT] = 1'b1;
        end
      end
      if (command_byte_i[`TDC_CMD_LAST_BUF]) begin
        d.frame_valid = 1'b1;
        d.tag_insert = tag_v && q.global_tag_enable;
        d.fcs_insert = (tag_v && q.global_tag_enable) || fcs_v;
        d.vlan_tag = spec_v;
        d.ethertype = q.tag_type;
        d.seg_ctx = command_byte_i[`TDC_CMD_SEG_OFF];
      end
      if (command_byte_i[`TDC_CMD_DLY_IRQ]) begin
        tload = 1'b1;
      end
      if (command_byte_i[`TDC_CMD_RPT_STAT] && command_byte_i[`TDC_CMD_RPT_WIRE]) begin
        d.fsm = TDC_WAIT;
        d.pend_ide = command_byte_i[`TDC_CMD_DLY_IRQ];
      end else if (command_byte_i[`TDC_CMD_RPT_STAT]) begin
        wb = 1'b1;
        ide_wb = command_byte_i[`TDC_CMD_DLY_IRQ];
      end else begin
        d.head_adv = 1'b1;
      end
    end else if (accept) begin
      // Unrecognised format is consumed with no effect on frames
      d.head_adv = 1'b1;
    end

    // Wire report pending
    case (q.fsm)
      TDC_IDLE: d.fsm = d.fsm;
      TDC_WAIT: begin
        if (resolve) begin
          wb = 1'b1;
          ide_wb = q.pend_ide;
          d.fsm = TDC_IDLE;
        end
      end
      default: d.fsm = TDC_IDLE;
    endcase

    if (wb) begin
      d.wb_valid = 1'b1;
      d.head_adv = 1'b1;
      if (ide_wb) begin
        tload = 1'b1;
      end else begin
        tclr = 1'b1;
        d.irq_stat[`TDC_IRQ_TX] = 1'b1;
      end
    end

    if (tif.expire) begin
      d.irq_stat[`TDC_IRQ_TX] = 1'b1;
    end
    d.irq = |(d.irq_stat & d.irq_mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.fsm <= TDC_IDLE;
      q.delay_value_field <= `TDC_RST_DELAY;
      q.tag_type <= `TDC_RST_TAG_TYPE;
      q.irq_mask <= `TDC_RST_MASK;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_o = q.rdata;
  assign desc_ready_o = (q.fsm == TDC_IDLE);
  assign frame_valid_o = q.frame_valid;
  assign tag_insert_o = q.tag_insert;
  assign fcs_insert_o = q.fcs_insert;
  assign vlan_tag_o = q.vlan_tag;
  assign ethertype_o = q.ethertype;
  assign seg_ctx_o = q.seg_ctx;
  assign seg_abort_o = q.seg_abort;
  assign descriptor_done_flag_o = q.wb_valid;
  assign head_advance_o = q.head_adv;
  assign irq_o = q.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rpw_taken;
    accept && fmt_ok && command_byte_i[`TDC_CMD_RPT_STAT] &&
      command_byte_i[`TDC_CMD_RPT_WIRE];
  endsequence

  sequence s_held_quiet;
    (!descriptor_done_flag_o && !head_advance_o);
  endsequence

  a_rpw_hold_quiet: assert property (s_rpw_taken ##1 !resolve |=> s_held_quiet)
    else $error("write-back or head move during wire wait");
  a_rpw_release: assert property (resolve |=> descriptor_done_flag_o && head_advance_o)
    else $error("wire wait not released on final packet");
  a_done_needs_rs: assert property (
    descriptor_done_flag_o |-> $past(resolve) ||
      $past(accept && fmt_ok && command_byte_i[`TDC_CMD_RPT_STAT]))
    else $error("done written without report status");
  a_irq_immediate: assert property ((wb && !ide_wb) |=> q.irq_stat[`TDC_IRQ_TX])
    else $error("immediate interrupt missing");
  a_tag_gated: assert property ((frame_valid_o && tag_insert_o) |->
    $past(q.global_tag_enable) && fcs_insert_o)
    else $error("tag inserted while disabled or without FCS");
  a_plain_fcs: assert property (
    (accept && fmt_ok && command_byte_i[`TDC_CMD_LAST_BUF] && !q.global_tag_enable)
      |=> !tag_insert_o && (fcs_insert_o == $past(fcs_v)))
    else $error("plain frame controls wrong");
  a_seg_abort: assert property (
    (accept && fmt_ok && command_byte_i[`TDC_CMD_SEG_OFF] &&
      command_byte_i[`TDC_CMD_LAST_BUF] && buffer_byte_length_i != rem_cur)
      |=> seg_abort_o ##1 !seg_abort_o)
    else $error("length mismatch not aborted");
  a_ctx_sample: assert property (
    (accept && fmt_ok && ctx_first && !command_byte_i[`TDC_CMD_LAST_BUF])
      |=> q.smp_special == $past(desc_special_i) && q.in_ctx)
    else $error("context fields not sampled from first");
  a_fmt_reject: assert property ((accept && !fmt_ok) |=> !frame_valid_o && !descriptor_done_flag_o)
    else $error("unrecognised descriptor acted on");
  a_reload_delay: assert property (
    (accept && fmt_ok && command_byte_i[`TDC_CMD_DLY_IRQ]) |-> tload)
    else $error("delay request did not reload countdown");
  a_irq_level: assert property (irq_o == |(q.irq_stat & q.irq_mask))
    else $error("interrupt level disagrees with status");
endmodule

// >>> verilog/tdc_delay_timer.sv
/*
  Interrupt delay countdown: load, clear, one-cycle expiry pulse at zero.
  Assumes load and clear come from the decoder on sys_clk_i.
*/
`timescale 1ns/1ps
`include "tdc_params.svh"

module tdc_delay_timer #(
  parameter int DLY_W = 16
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Control from the decoder
  tdc_timer_if.tmr tmr
);
  import tdc_pkg::*;

  typedef struct packed {
    logic [DLY_W-1:0] cnt;
    logic expire;
  } tdc_tmr_st_t;

  tdc_tmr_st_t q, d;

  // Load wins over clear so a reload is never dropped
  always_comb begin
    d = q;
    d.expire = 1'b0;
    if (tmr.load) begin
      d.cnt = tmr.value[DLY_W-1:0];
      d.expire = (tmr.value[DLY_W-1:0] == '0);
    end else if (tmr.clear) begin
      d.cnt = '0;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
      d.expire = (q.cnt == {{(DLY_W-1){1'b0}}, 1'b1});
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tmr.expire = q.expire;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_load_value: assert property (tmr.load |=> q.cnt == $past(tmr.value[DLY_W-1:0]))
    else $error("countdown not loaded with delay value");
  a_expire_zero: assert property (
    (q.cnt == {{(DLY_W-1){1'b0}}, 1'b1} && !tmr.load && !tmr.clear) |=> q.expire && q.cnt == '0)
    else $error("countdown reached zero without expiry");
  a_clear_stops: assert property ((tmr.clear && !tmr.load) |=> q.cnt == '0 && !q.expire)
    else $error("clear did not stop countdown");
endmodule

// >>> verilog/tdc_params.svh
/*
  Constants of the transmit data descriptor command decoder: command bit
  positions, format codes, register offsets and reset values.
  Assumes it is included by bare name from the package and design files.
*/
`ifndef TDC_PARAMS_SVH
`define TDC_PARAMS_SVH

// ----------------------------------------------------------------
// Command byte bit positions
// ----------------------------------------------------------------
`define TDC_CMD_DLY_IRQ 7
`define TDC_CMD_TAG_INS 6
`define TDC_CMD_EXT_FMT 5
`define TDC_CMD_RPT_WIRE 4
`define TDC_CMD_RPT_STAT 3
`define TDC_CMD_SEG_OFF 2
`define TDC_CMD_FCS_INS 1
`define TDC_CMD_LAST_BUF 0

// ----------------------------------------------------------------
// Descriptor format and widths
// ----------------------------------------------------------------
`define TDC_DTYPE_DATA 4'h1
`define TDC_LEN_W 16
`define TDC_ADDR_W 8
`define TDC_DATA_W 32

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TDC_OFS_CTRL 8'h00
`define TDC_OFS_DELAY 8'h04
`define TDC_OFS_TAG_TYPE 8'h08
`define TDC_OFS_IRQ_STAT 8'h0c
`define TDC_OFS_IRQ_MASK 8'h10
`define TDC_OFS_SEG_ABORT 8'h14
`define TDC_OFS_ENGINE 8'h18

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define TDC_CTRL_TAG_EN 0
`define TDC_IRQ_TX 0
`define TDC_IRQ_ABORT 1
`define TDC_ENG_WAIT 0
`define TDC_ENG_IN_CTX 1
`define TDC_RST_DELAY 16'h0000
`define TDC_RST_TAG_TYPE 16'h8100
`define TDC_RST_MASK 2'h0

`endif

// >>> verilog/tdc_pkg.sv
/*
  Types shared by the command decoder modules.
  Assumes the constants header is on the include path.
*/
`include "tdc_params.svh"

package tdc_pkg;

  // Write-back engine: idle, or holding for a report-on-wire packet
  typedef enum logic [1:0] {
    TDC_IDLE = 2'b01,
    TDC_WAIT = 2'b10
  } tdc_fsm_t;

  typedef logic [7:0] tdc_cmd_t;
  typedef logic [`TDC_LEN_W-1:0] tdc_len_t;

endpackage

// >>> verilog/tdc_stat_counter.sv
/*
  Saturating event counter for statistics.
  Assumes a one-cycle increment pulse on sys_clk_i.
*/
`timescale 1ns/1ps

module tdc_stat_counter #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Event and count
  input wire logic inc_i,
  output logic [W-1:0] count_o
);
  import tdc_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } tdc_cnt_st_t;

  tdc_cnt_st_t q, d;

  // Saturate rather than wrap so software never sees a false low count
  always_comb begin
    d = q;
    if (inc_i && q.cnt != '1) begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign count_o = q.cnt;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_count_inc: assert property ((inc_i && q.cnt != '1) |=> q.cnt == $past(q.cnt) + 1'b1)
    else $error("abort counter did not advance");
endmodule

// >>> verilog/tdc_timer_if.sv
/*
  Link between the decoder and its interrupt delay countdown.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps

interface tdc_timer_if;
  logic load;
  logic clear;
  logic [15:0] value;
  logic expire;

  modport ctl (output load, output clear, output value, input expire);
  modport tmr (input load, input clear, input value, output expire);
endinterface
